// *** hw/srs_shaper.v ***
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`include "srs_consts.vh"

// ==========================================================
// speed reference shaper top
module srs_shaper #(
   parameter MS_CYC = `SRS_CLK_HZ / `SRS_MS_PER_S
) (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // discrete pins
   input wire clamp_request_in,
   input wire proportional_ctrl_in,
   input wire position_done_in,
   // motor side
   input wire signed [15:0] motor_speed,
   input wire signed [31:0] motor_pos,
   output reg signed [15:0] speed_cmd_out,
   output reg clamped_out,
   output reg speed_match_out,
   output reg position_done_out,
   output reg [3:0] out_term_n
);

   // =======================================================
   // bus and config registers
   reg [13:0] acc_r, dec_r, flt_r, sct_r;
   reg [6:0] win_r;
   reg [11:0] clmp_r;
   reg [1:0] form_pend_r, form_r, shape_pend_r, shape_r;
   reg [3:0] mode_pend_r, mode_r;
   reg ina_r, inb_r;
   reg [1:0] oalloc_r;
   reg signed [15:0] ref_r;
   reg wr_pend_r;
   reg [11:0] waddr_r;
   reg [2:0] cl_s, pc_s, pd_s;
   reg [16:0] tick_r;
   reg signed [31:0] acc_q;
   reg signed [15:0] shaped_r;
   reg signed [31:0] hold_pos_r;
   reg clamp_r;
   reg [31:0] rd_nxt;

   wire tick = (tick_r == MS_CYC[16:0] - 17'h00001);
   wire clamp_req_n = ((ina_r | inb_r) ? cl_s[1] : 1'b1);
   wire speed_mode = (mode_r == `SRS_MODE_SPEED) ||
      (mode_r == `SRS_MODE_CLAMP);
   wire pos_mode = (mode_r == `SRS_MODE_POS);

   // =======================================================
   // helper functions
   function [15:0] absv;
      input signed [15:0] v;
      begin
         absv = v[15] ? -v : v;
      end
   endfunction

   // per-ms step: 1000 rpm over t ms
   function [15:0] step_of;
      input [13:0] t;
      reg [31:0] q;
      begin
         if (t == 14'h0000) begin
            q = 32'h00000000;
            step_of = 16'h7FFF;
         end else begin
            q = `SRS_RAMP_RPM / t;
            step_of = q[15:0];
         end
      end
   endfunction

   // per-ms step that covers 0 to the target in t ms
   function [15:0] s_step_of;
      input [15:0] mag;
      input [13:0] t;
      reg [16:0] q;
      begin
         if (t == 14'h0000) begin
            q = 17'h00000;
            s_step_of = 16'h7FFF;
         end else begin
            q = {1'b0, mag} / {3'h0, t} + 17'h00001;
            s_step_of = q[15:0];
         end
      end
   endfunction

   // sign extension by one bit
   function [16:0] sx17;
      input [15:0] v;
      begin
         sx17 = {v[15], v};
      end
   endfunction

   // one lag step in 16.16: (x - y) / tau
   function [31:0] lag_inc;
      input [16:0] d;
      input [13:0] tau;
      reg signed [47:0] num;
      reg signed [47:0] q;
      begin
         num = $signed({{15{d[16]}}, d, 16'h0000});
         q = num / $signed({34'h0, tau});
         lag_inc = q[31:0];
      end
   endfunction

   // clip a position error to the command range
   function [15:0] sat16;
      input [31:0] v;
      begin
         if (!v[31] && v[30:15] != 16'h0000)
            sat16 = 16'h7FFF;
         else if (v[31] && v[30:15] != 16'hFFFF)
            sat16 = 16'h8000;
         else
            sat16 = v[15:0];
      end
   endfunction

   // =======================================================
   // ahb-lite slave
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         waddr_r <= 12'h000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_r <= hsel && hready && htrans[1] && hwrite;
         if (hsel && hready && htrans[1]) begin
            waddr_r <= haddr[11:0];
            hrdata <= hwrite ? 32'h00000000 : rd_nxt;
         end
      end
   end

   always @* begin
      case (haddr[11:0])
         `SRS_A_CTRL: rd_nxt = {18'h0, oalloc_r, 1'b0, inb_r, ina_r,
            1'b0, mode_r, shape_r, form_r};
         `SRS_A_ACC: rd_nxt = {18'h0, acc_r};
         `SRS_A_DEC: rd_nxt = {18'h0, dec_r};
         `SRS_A_FLT: rd_nxt = {18'h0, flt_r};
         `SRS_A_SCT: rd_nxt = {18'h0, sct_r};
         `SRS_A_WIN: rd_nxt = {25'h0, win_r};
         `SRS_A_CLMP: rd_nxt = {20'h0, clmp_r};
         `SRS_A_REF: rd_nxt = {{16{ref_r[15]}}, ref_r};
         `SRS_A_SPD: rd_nxt = {{16{shaped_r[15]}}, shaped_r};
         `SRS_A_OUT: rd_nxt = {28'h0, out_term_n};
         `SRS_A_STAT: rd_nxt = {29'h0, position_done_out,
            speed_match_out, clamp_r};
         `SRS_A_MPOS: rd_nxt = hold_pos_r;
         default: rd_nxt = 32'h00000000;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_r <= `SRS_RST_ACC;
         dec_r <= `SRS_RST_DEC;
         flt_r <= `SRS_RST_FLT;
         sct_r <= `SRS_RST_SCT;
         win_r <= `SRS_RST_WIN;
         clmp_r <= `SRS_RST_CLMP;
         form_pend_r <= `SRS_FORM_RAMP;
         form_r <= `SRS_FORM_RAMP;
         shape_pend_r <= 2'h0;
         shape_r <= 2'h0;
         mode_pend_r <= `SRS_MODE_SPEED;
         mode_r <= `SRS_MODE_SPEED;
         ina_r <= 1'b0;
         inb_r <= 1'b0;
         oalloc_r <= 2'h0;
         ref_r <= 16'h0000;
      end else if (wr_pend_r) begin
         case (waddr_r)
            `SRS_A_CTRL: begin
               form_pend_r <= hwdata[`SRS_F_FORM_LO +: 2];
               shape_pend_r <= hwdata[`SRS_F_SHAPE_LO +: 2];
               mode_pend_r <= hwdata[`SRS_F_MODE_LO +: 4];
               ina_r <= hwdata[`SRS_F_INA];
               inb_r <= hwdata[`SRS_F_INB];
               oalloc_r <= hwdata[`SRS_F_OALLOC_LO +: 2];
               if (hwdata[`SRS_F_RESTART]) begin
                  form_r <= hwdata[`SRS_F_FORM_LO +: 2];
                  shape_r <= hwdata[`SRS_F_SHAPE_LO +: 2];
                  mode_r <= hwdata[`SRS_F_MODE_LO +: 4];
               end
            end
            `SRS_A_ACC: acc_r <= hwdata[13:0];
            `SRS_A_DEC: dec_r <= hwdata[13:0];
            `SRS_A_FLT: flt_r <= hwdata[13:0];
            `SRS_A_SCT: sct_r <= hwdata[13:0];
            `SRS_A_WIN: win_r <= hwdata[6:0];
            `SRS_A_CLMP: clmp_r <= hwdata[11:0];
            `SRS_A_REF: ref_r <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // =======================================================
   // pin synchronisers and ms tick
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cl_s <= 3'h7;
         pc_s <= 3'h7;
         pd_s <= 3'h0;
         tick_r <= 17'h00000;
      end else begin
         cl_s <= {cl_s[1:0], clamp_request_in};
         pc_s <= {pc_s[1:0], proportional_ctrl_in};
         pd_s <= {pd_s[1:0], position_done_in};
         tick_r <= tick ? 17'h00000 : tick_r + 17'h00001;
      end
   end

   // =======================================================
   // reference shaping
   reg [15:0] up_step, dn_step, act_step;
   reg signed [16:0] diff;
   reg rising;
   always @* begin
      diff = sx17(ref_r) - sx17(shaped_r);
      rising = absv(ref_r) > absv(shaped_r);
      if (form_r == `SRS_FORM_SCURVE) begin
         // one time covers stop to target
         up_step = s_step_of(absv(ref_r), sct_r);
         dn_step = up_step;
      end else begin
         up_step = step_of(acc_r);
         dn_step = step_of(dec_r);
      end
      act_step = rising ? up_step : dn_step;
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shaped_r <= 16'h0000;
         acc_q <= 32'h00000000;
      end else if (form_r[1]) begin
         // first-order lag, per ms: y += (x-y)/tau
         if (flt_r == 14'h0000) begin
            shaped_r <= ref_r;
            acc_q <= {ref_r, 16'h0000};
         end else if (tick) begin
            acc_q <= acc_q + lag_inc(diff, flt_r);
            shaped_r <= acc_q[31:16];
         end
      end else if (tick || act_step == 16'h7FFF) begin
         // ramp or s-curve slope limit
         if (absv(diff[15:0]) <= act_step || diff[16] != diff[15])
            shaped_r <= ref_r;
         else if (diff[16])
            shaped_r <= shaped_r - act_step;
         else
            shaped_r <= shaped_r + act_step;
      end
   end

   // =======================================================
   // zero clamp and position loop
   wire below = absv(ref_r) < {4'h0, clmp_r};
   wire clamp_en = (mode_r == `SRS_MODE_CLAMP) ? !pc_s[1] :
      !clamp_req_n;
   wire signed [31:0] perr = hold_pos_r - motor_pos;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clamp_r <= 1'b0;
         hold_pos_r <= 32'h00000000;
         speed_cmd_out <= 16'h0000;
         clamped_out <= 1'b0;
      end else begin
         clamp_r <= speed_mode && clamp_en && below;
         clamped_out <= clamp_r;
         if (!clamp_r)
            hold_pos_r <= motor_pos;
         if (clamp_r) begin
            // proportional pull back, deadband one pulse
            if (perr > `SRS_HOLD_TOL || perr < -`SRS_HOLD_TOL)
               speed_cmd_out <= sat16(perr);
            else
               speed_cmd_out <= 16'h0000;
         end else
            speed_cmd_out <= shaped_r;
      end
   end

   // =======================================================
   // speed match and output routing
   wire signed [16:0] serr = sx17(motor_speed) - sx17(shaped_r);
   wire [16:0] serr_abs = serr[16] ? -serr : serr;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         speed_match_out <= 1'b1;
         position_done_out <= 1'b1;
         out_term_n <= 4'hF;
      end else begin
         // active low when |error| below window in speed or clamp mode, on position done in position mode
         if (pos_mode)
            speed_match_out <= !pd_s[1];
         else
            speed_match_out <= !(speed_mode &&
               serr_abs < {10'h0, win_r});
         position_done_out <= !pd_s[1];
         out_term_n <= 4'hF;
         out_term_n[oalloc_r] <= speed_match_out;
      end
   end

endmodule // srs_shaper

// *** hw/srs_consts.vh ***
`ifndef SRS_CONSTS_VH
`define SRS_CONSTS_VH
// ==========================================================
// register byte offsets
`define SRS_A_CTRL 12'h000
`define SRS_A_ACC 12'h004
`define SRS_A_DEC 12'h008
`define SRS_A_FLT 12'h00C
`define SRS_A_SCT 12'h010
`define SRS_A_WIN 12'h014
`define SRS_A_CLMP 12'h018
`define SRS_A_REF 12'h01C
`define SRS_A_SPD 12'h020
`define SRS_A_OUT 12'h024
`define SRS_A_STAT 12'h028
`define SRS_A_MPOS 12'h02C
// ==========================================================
// ctrl field positions
`define SRS_F_FORM_LO 0
`define SRS_F_SHAPE_LO 2
`define SRS_F_MODE_LO 4
`define SRS_F_RESTART 8
`define SRS_F_INA 9
`define SRS_F_INB 10
`define SRS_F_OALLOC_LO 12
// ==========================================================
// reset values
`define SRS_RST_ACC 14'h0000
`define SRS_RST_DEC 14'h0000
`define SRS_RST_FLT 14'h0000
`define SRS_RST_SCT 14'h0000
`define SRS_RST_WIN 7'h0A
`define SRS_RST_CLMP 12'h00A
// ==========================================================
// encodings and scale
`define SRS_FORM_RAMP 2'h0
`define SRS_FORM_SCURVE 2'h1
`define SRS_MODE_SPEED 4'h0
`define SRS_MODE_POS 4'h1
`define SRS_MODE_CLAMP 4'hA
`define SRS_RAMP_RPM 1000
`define SRS_CLK_HZ 10000000
`define SRS_MS_PER_S 1000
`define SRS_HOLD_TOL 1
`endif

// *** bench/srs_host_model.sv ***
module srs_host_model (
   // bench commands and drive command
   input wire logic hclk,
   input wire logic clamp_cmd,
   input wire logic pcon_cmd,
   input wire logic pdone_cmd,
   input wire logic signed [15:0] spd_off,
   input wire logic signed [31:0] push,
   input wire logic signed [15:0] speed_cmd_out,
   // pins and motor feedback
   output logic clamp_request_in = 1'b1,
   output logic proportional_ctrl_in = 1'b1,
   output logic position_done_in = 1'b0,
   output logic signed [15:0] motor_speed = 16'sh0000,
   output logic signed [31:0] motor_pos = 32'sh0
);
   timeunit 1ns;
   timeprecision 1ns;
   // ====
   // host pins, motor follows the command one pulse a cycle
   always @(posedge hclk) begin
      clamp_request_in <= clamp_cmd;
      proportional_ctrl_in <= pcon_cmd;
      position_done_in <= pdone_cmd;
      motor_speed <= speed_cmd_out + spd_off;
      motor_pos <= motor_pos + push + 32'(speed_cmd_out > 16'sh0000)
         - 32'(speed_cmd_out < 16'sh0000);
   end
endmodule // srs_host_model

// *** bench/srs_shaper_assertions.sv ***
module srs_shaper_assertions (
   // clock, reset, bus
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [1:0] htrans,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   // pins
   input wire clamp_request_in,
   input wire proportional_ctrl_in,
   input wire signed [15:0] speed_cmd_out,
   input wire clamped_out,
   input wire speed_match_out,
   input wire position_done_out,
   input wire [3:0] out_term_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // ====
   // recent clamp causes
   logic [5:0] low_hist;
   wire req_low = !clamp_request_in || !proportional_ctrl_in;
   wire taken = hsel && hready && htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         low_hist <= 6'h00;
      else
         low_hist <= {low_hist[4:0], req_low};
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence pins_idle;
      (clamp_request_in && proportional_ctrl_in) [*5];
   endsequence
   AST_READY: assert property (hreadyout)
      else $error("ready low");
   AST_RESP: assert property (!hresp)
      else $error("error response");
   AST_RDATA_HOLD: assert property (!$past(taken) |-> $stable(hrdata))
      else $error("read data moved");
   AST_RST_IDLE: assert property ($rose(hresetn) |-> speed_match_out
      && position_done_out && !clamped_out && out_term_n == 4'hF
      && speed_cmd_out == 16'sh0000)
      else $error("outputs not idle after reset");
   AST_UNCLAMP: assert property (pins_idle |=> !clamped_out)
      else $error("clamp without request");
   AST_CLAMP_CAUSE: assert property ($rose(clamped_out) |-> low_hist != 6'h00)
      else $error("clamp with no cause");
   AST_TERM_ONE: assert property ($countones(~out_term_n) <= 1)
      else $error("several terminals low");
   AST_TERM_SRC: assert property (out_term_n != 4'hF |-> !$past(speed_match_out))
      else $error("terminal low without match");
endmodule // srs_shaper_assertions
bind srs_shaper srs_shaper_assertions srs_shaper_assertions_i (.hclk,
   .hresetn, .hsel, .htrans, .hready, .hrdata, .hreadyout, .hresp,
   .clamp_request_in, .proportional_ctrl_in, .speed_cmd_out, .clamped_out,
   .speed_match_out, .position_done_out, .out_term_n);

// *** bench/tb_srs_shaper.sv ***
`include "srs_consts.vh"
`define CHK(nm, e, s) begin \
   comparisons++; \
   if ((s) !== (e)) begin \
      failures++; \
      $display("BAD %s exp %0h got %0h", nm, (e), (s)); \
   end \
end
module tb_srs_shaper;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
   logic clamp_cmd = 1'b1, pcon_cmd = 1'b1, pdone_cmd = 1'b0;
   logic signed [15:0] spd_off = 16'sh0000;
   logic signed [31:0] push = 32'sh0, hold;
   wire [31:0] hrdata;
   wire hreadyout, hresp, clamp_request_in, proportional_ctrl_in;
   wire position_done_in, clamped_out, speed_match_out, position_done_out;
   wire signed [15:0] motor_speed, speed_cmd_out;
   wire signed [31:0] motor_pos;
   wire [3:0] out_term_n;
   int failures = 0, comparisons = 0, n;
   // address, reset value, write value, read back
   logic [31:0] rows [7][4] = '{'{`SRS_A_ACC, 0, 32'h2710, 32'h2710},
      '{`SRS_A_DEC, 0, 32'h2710, 32'h2710}, '{`SRS_A_SCT, 0, 32'h2710, 32'h2710},
      '{`SRS_A_FLT, 0, 32'h2710, 32'h2710}, '{`SRS_A_WIN, 32'hA, 32'h64, 32'h64},
      '{`SRS_A_CLMP, 32'hA, 32'hBB8, 32'hBB8}, '{32'h40, 0, 32'h5, 0}};
   logic [15:0] offs [4] = '{16'h0009, 16'h000A, 16'hFFF7, 16'h00C8};
   logic mexp [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
   always #50 hclk = ~hclk;
   srs_shaper #(.MS_CYC(10)) srs_shaper_i (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .clamp_request_in, .proportional_ctrl_in,
      .position_done_in, .motor_speed, .motor_pos, .speed_cmd_out,
      .clamped_out, .speed_match_out, .position_done_out, .out_term_n);
   srs_host_model srs_host_model_i (.hclk, .clamp_cmd, .pcon_cmd, .pdone_cmd,
      .spd_off, .push, .speed_cmd_out, .clamp_request_in,
      .proportional_ctrl_in, .position_done_in, .motor_speed, .motor_pos);
   task give_verdict;
      if (failures == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task waitrdy;
      n = 0;
      do
         @(posedge hclk);
      while (hreadyout !== 1'b1 && ++n < 20);
      if (n >= 20) begin
         failures++;
         give_verdict;
      end
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h00000, a};
      waitrdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitrdy;
      q = hrdata;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task ctrl(input logic [31:0] v);
      wr(`SRS_A_CTRL, v | 32'h100);
   endtask
   task times(input logic [31:0] t);
      wr(`SRS_A_ACC, t);
      wr(`SRS_A_DEC, t);
      wr(`SRS_A_FLT, t);
      wr(`SRS_A_SCT, t);
   endtask
   task waitc(input logic v);
      n = 0;
      while (clamped_out !== v && n < 40) begin
         @(posedge hclk);
         n++;
      end
      `CHK("clamp", v, clamped_out)
      if (clamped_out !== v)
         give_verdict;
   endtask
   // ====
   // main sequence
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 7; i++) begin
         bus(1'b0, rows[i][0][11:0], 32'h0);
         `CHK("reset", rows[i][1], q)
         wr(rows[i][0][11:0], rows[i][2]);
         bus(1'b0, rows[i][0][11:0], 32'h0);
         `CHK("readback", rows[i][3], q)
      end
      wr(`SRS_A_WIN, 32'hA);
      wr(`SRS_A_CLMP, 32'hA);
      for (int f = 0; f < 4; f++) begin
         ctrl(32'(f * 5));
         times(0);
         wr(`SRS_A_REF, 0);
         repeat (4) @(posedge hclk);
         times(32'hA);
         wr(`SRS_A_REF, 32'h3E8);
         repeat (30) @(posedge hclk);
         `CHK("mid", 1'b1, speed_cmd_out > 16'sh0 && speed_cmd_out < 16'sh3E8)
         repeat (120) @(posedge hclk);
         if (f < 2)
            `CHK("end", 16'sh03E8, speed_cmd_out)
         if (f == 0) begin
            wr(`SRS_A_REF, 32'h1F4);
            repeat (30) @(posedge hclk);
            `CHK("dec", 1'b1, speed_cmd_out > 16'sh1F4 && speed_cmd_out < 16'sh3E8)
            repeat (40) @(posedge hclk);
            `CHK("dec", 16'sh01F4, speed_cmd_out)
         end
      end
      ctrl(32'h2000);
      times(0);
      wr(`SRS_A_FLT, 32'hA);
      wr(`SRS_A_CTRL, 32'h2002);
      wr(`SRS_A_REF, 32'h123);
      repeat (4) @(posedge hclk);
      `CHK("pass", 16'sh0123, speed_cmd_out)
      for (int k = 0; k < 4; k++) begin
         spd_off <= offs[k];
         repeat (6) @(posedge hclk);
         `CHK("match", mexp[k], speed_match_out)
         `CHK("term", {1'b1, mexp[k], 2'h3}, out_term_n)
      end
      ctrl(32'h10);
      pdone_cmd <= 1'b1;
      repeat (6) @(posedge hclk);
      `CHK("posmatch", 1'b0, speed_match_out)
      `CHK("posdone", 1'b0, position_done_out)
      pdone_cmd <= 1'b0;
      spd_off <= 16'sh0000;
      repeat (6) @(posedge hclk);
      `CHK("posmatch", 1'b1, speed_match_out)
      ctrl(0);
      wr(`SRS_A_REF, 0);
      clamp_cmd <= 1'b0;
      repeat (10) @(posedge hclk);
      `CHK("unassigned", 1'b0, clamped_out)
      ctrl(32'h200);
      waitc(1'b1);
      hold = motor_pos;
      wr(`SRS_A_REF, 32'h5);
      repeat (6) @(posedge hclk);
      `CHK("ignore", 16'sh0000, speed_cmd_out)
      push <= 32'sh5;
      @(posedge hclk);
      push <= 32'sh0;
      repeat (100) @(posedge hclk);
      `CHK("hold", 1'b1, motor_pos - hold <= 32'sh1 && hold - motor_pos <= 32'sh1)
      wr(`SRS_A_REF, 32'h1F4);
      waitc(1'b0);
      wr(`SRS_A_REF, 0);
      ctrl(32'h400);
      waitc(1'b1);
      clamp_cmd <= 1'b1;
      waitc(1'b0);
      ctrl(32'hA0);
      pcon_cmd <= 1'b0;
      waitc(1'b1);
      pcon_cmd <= 1'b1;
      waitc(1'b0);
      wr(`SRS_A_WIN, 32'h32);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, `SRS_A_WIN, 32'h0);
      `CHK("window", 32'hA, q)
      give_verdict;
   end
endmodule // tb_srs_shaper
